//--- inc/qdc_readout_params.svh
`ifndef QDC_READOUT_PARAMS_SVH
`define QDC_READOUT_PARAMS_SVH

// Register offsets
`define OFF_CTRL1       16'h1010
`define OFF_ADDR_HI     16'h1012
`define OFF_ADDR_LO     16'h1014
`define OFF_ONESHOT     16'h1016
`define OFF_CHAIN       16'h101a
`define OFF_IRQ_THR     16'h1020
`define OFF_STATUS2     16'h1022
`define OFF_CNT_LO      16'h1024
`define OFF_CNT_HI      16'h1026
`define OFF_NEXT_EVT    16'h1028
`define OFF_NEXT_WORD   16'h102a
`define OFF_FC_WIN      16'h102e
`define OFF_MODE_SET    16'h1032
`define OFF_MODE_CLR    16'h1034
`define OFF_CNT_RST     16'h1040

// Control register one fields
`define CTRL1_BLOCK_END 2
`define CTRL1_FRONT_MODE 4
`define CTRL1_BERR_EN   5
`define CTRL1_ALIGN     6
`define CTRL1_MASK      16'h0074
`define CTRL1_KEEP_MASK 16'h0010

// Mode register fields and reset value
`define MODE_CLEAR_DATA 2
`define MODE_READ_PTR_AUTO_ADVANCE  11
`define MODE_COUNT_EVERY_TRIGGER    14
`define MODE_RESET      16'h4800

// Chain control fields
`define CHAIN_LAST_BIT  0
`define CHAIN_FIRST_BIT 1

// Buffer status fields
`define STAT2_EMPTY     1
`define STAT2_FULL      2
`define STAT2_DTYPE_LSB 4

// Data word layout
`define WORD_TYPE_MSB   26
`define WORD_TYPE_LSB   24
`define TYPE_EOB        3'h4
`define NOT_VALID_WORD  32'h0600_0000

// Widths
`define THR_BITS        5
`define FC_BITS         10

// Fast-clear window timing
`define FC_BASE_NS      7000
`define FC_STEP_PS      31250
`define CLK_PERIOD_PS   10000

`endif

//--- inc/qdc_readout_pkg.sv
package qdc_readout_pkg;
  typedef enum logic [1:0] {
    CHAIN_OFF,
    CHAIN_FIRST,
    CHAIN_LAST,
    CHAIN_MIDDLE
  } chain_role_e;
endpackage

//--- verilog/qdc_readout_control_regs.sv
`timescale 1ns/1ns
`include "qdc_readout_params.svh"
module qdc_readout_control_regs #(
  parameter int BUF_AW = 6
) (
  input  wire logic                              clk,
  input  wire logic                              reset,
  input  wire logic [15:0]                       reg_addr,
  input  wire logic [15:0]                       reg_wdata,
  input  wire logic                              reg_write,
  input  wire logic                              reg_read,
  output logic      [15:0]                       reg_rdata,
  output logic                                   reg_ack,
  input  wire logic [31:0]                       acq_word,
  input  wire logic                              acq_valid,
  output logic                                   acq_ready,
  input  wire logic                              trigger_seen,
  input  wire logic                              event_accepted,
  input  wire logic                              readout_active,
  input  wire logic                              block_transfer,
  output logic      [31:0]                       out_word,
  output logic                                   out_valid,
  input  wire logic                              out_ready,
  output logic                                   bus_error_output,
  input  wire logic                              front_reset,
  input  wire logic                              soft_reset_hold,
  input  wire logic                              select_decoder,
  input  wire logic [15:0]                       rotary_addr,
  output logic      [15:0]                       module_base_addr,
  input  wire logic                              daughter_type_c1,
  input  wire logic                              daughter_type_c0,
  input  wire logic                              daughter_type_d1,
  input  wire logic                              daughter_type_d0,
  input  wire logic                              irq_ack,
  output logic                                   irq_request,
  output qdc_readout_pkg::chain_role_e           chain_role,
  output logic      [`FC_BITS-1:0]               fast_clear_width,
  output logic      [15:0]                       fast_clear_cycles
);
  localparam int DEPTH = 1 << BUF_AW;

  // Control and mode state
  logic [15:0]           ctrl1;
  logic [7:0]            addr_hi;
  logic [7:0]            addr_lo;
  logic [1:0]            chain_bits;
  logic [`THR_BITS-1:0]  irq_thr;
  logic [15:0]           mode;
  logic [23:0]           evt_count;

  // Output buffer state
  logic [31:0]           buf_mem [DEPTH];
  logic [BUF_AW:0]       wr_ptr;
  logic [BUF_AW:0]       rd_ptr;
  logic [BUF_AW:0]       stored_events;
  logic                  skip_event;
  logic                  blk_done;
  logic                  pad_pending;
  logic                  word_parity;
  logic                  irq_cond_q;

  // Two-entry output buffer
  logic [32:0]           ent [2];
  logic                  ent_wr_sel;
  logic                  ent_rd_sel;
  logic [1:0]            ent_count;

  // Register decode
  wire  sel_ctrl1     = reg_addr == `OFF_CTRL1;
  wire  sel_addr_hi   = reg_addr == `OFF_ADDR_HI;
  wire  sel_addr_lo   = reg_addr == `OFF_ADDR_LO;
  wire  sel_chain     = reg_addr == `OFF_CHAIN;
  wire  sel_thr       = reg_addr == `OFF_IRQ_THR;
  wire  sel_stat2     = reg_addr == `OFF_STATUS2;
  wire  sel_cnt_lo    = reg_addr == `OFF_CNT_LO;
  wire  sel_cnt_hi    = reg_addr == `OFF_CNT_HI;
  wire  sel_fc        = reg_addr == `OFF_FC_WIN;
  wire  sel_mode      = reg_addr == `OFF_MODE_SET;
  wire  wr_ctrl1      = reg_write & sel_ctrl1;
  wire  wr_mode_set   = reg_write & sel_mode;
  wire  wr_mode_clr   = reg_write & (reg_addr == `OFF_MODE_CLR);
  wire  wr_oneshot    = reg_write & (reg_addr == `OFF_ONESHOT);
  wire  wr_next_evt   = reg_write & (reg_addr == `OFF_NEXT_EVT);
  wire  wr_next_word  = reg_write & (reg_addr == `OFF_NEXT_WORD);
  wire  wr_cnt_rst    = reg_write & (reg_addr == `OFF_CNT_RST);

  // Mode fields
  wire  front_mode    = ctrl1[`CTRL1_FRONT_MODE];
  wire  block_end     = ctrl1[`CTRL1_BLOCK_END];
  wire  berr_en       = ctrl1[`CTRL1_BERR_EN];
  wire  align_en      = ctrl1[`CTRL1_ALIGN];
  wire  auto_advance  = mode[`MODE_READ_PTR_AUTO_ADVANCE];
  wire  count_all     = mode[`MODE_COUNT_EVERY_TRIGGER];

  // Reset pulses: one-shot, front panel by mode, held software reset
  wire  soft_pulse    = wr_oneshot | (front_reset & front_mode) | soft_reset_hold;
  wire  data_pulse    = soft_pulse | (front_reset & ~front_mode) | mode[`MODE_CLEAR_DATA];

  // Buffer status
  wire  buf_empty     = wr_ptr == rd_ptr;
  wire  buf_full      = wr_ptr == {~rd_ptr[BUF_AW], rd_ptr[BUF_AW-1:0]};
  wire [31:0] head    = buf_mem[rd_ptr[BUF_AW-1:0]];
  wire  head_eob      = head[`WORD_TYPE_MSB:`WORD_TYPE_LSB] == `TYPE_EOB;
  wire  head_last     = (wr_ptr - rd_ptr) == (BUF_AW+1)'(1);
  wire  acq_push      = acq_valid & acq_ready & ~data_pulse;
  wire  acq_eob       = acq_word[`WORD_TYPE_MSB:`WORD_TYPE_LSB] == `TYPE_EOB;

  // Readout engine: choose the next word for the two-entry buffer
  wire  ent_in_ready  = ent_count != 2'd2;
  wire  emit_valid    = readout_active & ent_in_ready & ~data_pulse;
  wire  emit_nv       = pad_pending | (block_end & blk_done) | buf_empty;
  wire  emit_data     = emit_valid & ~emit_nv;
  wire [31:0] emit_word = emit_nv ? `NOT_VALID_WORD : head;
  wire  emit_berr     = emit_data & berr_en & block_transfer &
                        (block_end ? head_eob : head_last);
  wire  emit_pop      = emit_data & auto_advance;
  wire  word_pop      = wr_next_word & ~buf_empty;
  wire  skip_pop      = skip_event & ~buf_empty;
  wire  pop           = (emit_pop | word_pop | skip_pop) & ~data_pulse;
  wire  pop_eob       = pop & head_eob;
  wire  odd_event     = ~word_parity;

  // Event counting and interrupt condition
  wire  cnt_inc       = count_all ? trigger_seen : event_accepted;
  wire  cnt_clear     = wr_cnt_rst | soft_pulse | (data_pulse & ~count_all);
  wire  irq_cond      = (irq_thr != '0) &&
                        (32'(stored_events) == 32'(irq_thr));

  // Fast-clear window in clock cycles, rounded down
  wire [31:0] fc_ps   = 32'(`FC_BASE_NS) * 32'd1000 + 32'(fast_clear_width) * 32'(`FC_STEP_PS);

  assign acq_ready        = ~buf_full;
  assign out_valid        = ent_count != 2'd0;
  assign out_word         = ent[ent_rd_sel][31:0];
  assign bus_error_output = ent[ent_rd_sel][32];
  assign module_base_addr = select_decoder ? {addr_hi, addr_lo} : rotary_addr;
  assign fast_clear_cycles = 16'(fc_ps / 32'(`CLK_PERIOD_PS));

  // Chain role from first and last bits
  always_comb begin
    case (chain_bits)
      2'b10:   chain_role = qdc_readout_pkg::CHAIN_FIRST;
      2'b01:   chain_role = qdc_readout_pkg::CHAIN_LAST;
      2'b11:   chain_role = qdc_readout_pkg::CHAIN_MIDDLE;
      default: chain_role = qdc_readout_pkg::CHAIN_OFF;
    endcase
  end

  // Read data mux
  logic [15:0] next_rdata;
  always_comb begin
    next_rdata = 16'h0000;
    if (sel_ctrl1) next_rdata = ctrl1;
    if (sel_addr_hi) next_rdata = {8'h00, addr_hi};
    if (sel_addr_lo) next_rdata = {8'h00, addr_lo};
    if (sel_thr) next_rdata = 16'(irq_thr);
    if (sel_stat2) begin
      next_rdata[`STAT2_EMPTY] = buf_empty;
      next_rdata[`STAT2_FULL] = buf_full;
      next_rdata[`STAT2_DTYPE_LSB +: 4] = {daughter_type_c1, daughter_type_c0,
                                           daughter_type_d1, daughter_type_d0};
    end
    if (sel_cnt_lo) next_rdata = evt_count[15:0];
    if (sel_cnt_hi) next_rdata = {8'h00, evt_count[23:16]};
    if (sel_fc) next_rdata = 16'(fast_clear_width);
    if (sel_mode) next_rdata = mode;
  end

  // Register bus answer, one cycle after the strobe
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 16'h0000;
      reg_ack   <= 1'b0;
    end else begin
      reg_rdata <= reg_read ? next_rdata : 16'h0000;
      reg_ack   <= reg_read | reg_write;
    end
  end

  // Control register one: soft reset keeps only the front mode bit
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl1 <= 16'h0000;
    end else if (wr_ctrl1) begin
      ctrl1 <= reg_wdata & `CTRL1_MASK;
    end else if (soft_pulse) begin
      ctrl1 <= ctrl1 & `CTRL1_KEEP_MASK;
    end
  end

  // Address decoder, chain, threshold, fast-clear and mode registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      addr_hi          <= 8'h00;
      addr_lo          <= 8'h00;
      chain_bits       <= 2'b00;
      irq_thr          <= '0;
      fast_clear_width <= '0;
      mode             <= `MODE_RESET;
    end else begin
      if (reg_write && sel_addr_hi) addr_hi <= reg_wdata[7:0];
      if (reg_write && sel_addr_lo) addr_lo <= reg_wdata[7:0];
      if (reg_write && sel_chain) chain_bits <= {reg_wdata[`CHAIN_FIRST_BIT], reg_wdata[`CHAIN_LAST_BIT]};
      if (reg_write && sel_thr) irq_thr <= reg_wdata[`THR_BITS-1:0];
      if (reg_write && sel_fc) fast_clear_width <= reg_wdata[`FC_BITS-1:0];
      if (wr_mode_set) mode <= mode | reg_wdata;
      if (wr_mode_clr) mode <= mode & ~reg_wdata;
    end
  end

  // Event counter
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      evt_count <= 24'h000000;
    end else if (cnt_clear) begin
      evt_count <= 24'h000000;
    end else if (cnt_inc) begin
      evt_count <= evt_count + 24'h000001;
    end
  end

  // Output buffer write side
  always_ff @(posedge clk) begin
    if (acq_push) buf_mem[wr_ptr[BUF_AW-1:0]] <= acq_word;
  end

  // Buffer pointers and stored event count
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_ptr        <= '0;
      rd_ptr        <= '0;
      stored_events <= '0;
    end else if (data_pulse) begin
      wr_ptr        <= '0;
      rd_ptr        <= '0;
      stored_events <= '0;
    end else begin
      if (acq_push) wr_ptr <= wr_ptr + (BUF_AW+1)'(1);
      if (pop) rd_ptr <= rd_ptr + (BUF_AW+1)'(1);
      stored_events <= stored_events + (BUF_AW+1)'(acq_push & acq_eob) - (BUF_AW+1)'(pop_eob);
    end
  end

  // Event skip, block-end latch, alignment pad and word parity
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      skip_event  <= 1'b0;
      blk_done    <= 1'b0;
      pad_pending <= 1'b0;
      word_parity <= 1'b0;
    end else if (data_pulse) begin
      skip_event  <= 1'b0;
      blk_done    <= 1'b0;
      pad_pending <= 1'b0;
      word_parity <= 1'b0;
    end else begin
      if (wr_next_evt) skip_event <= 1'b1;
      else if (pop_eob) skip_event <= 1'b0;
      if (!block_transfer) blk_done <= 1'b0;
      else if (emit_data && head_eob && block_end) blk_done <= 1'b1;
      if (emit_valid && pad_pending) pad_pending <= 1'b0;
      else if (emit_data && head_eob) pad_pending <= align_en & block_transfer & odd_event;
      if (emit_data) word_parity <= head_eob ? 1'b0 : ~word_parity;
    end
  end

  // Interrupt request held until the condition ends or acknowledge
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_request <= 1'b0;
      irq_cond_q  <= 1'b0;
    end else begin
      irq_cond_q <= irq_cond;
      if (irq_cond && !irq_cond_q) irq_request <= 1'b1;
      else if (!irq_cond || irq_ack) irq_request <= 1'b0;
    end
  end

  // Two-entry output buffer, stall from the receiver holds the engine
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ent[0]     <= 33'h0;
      ent[1]     <= 33'h0;
      ent_wr_sel <= 1'b0;
      ent_rd_sel <= 1'b0;
      ent_count  <= 2'd0;
    end else begin
      if (emit_valid) begin
        ent[ent_wr_sel] <= {emit_berr, emit_word};
        ent_wr_sel      <= ~ent_wr_sel;
      end
      if (out_valid && out_ready) ent_rd_sel <= ~ent_rd_sel;
      ent_count <= ent_count + 2'(emit_valid) - 2'(out_valid & out_ready);
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  irq_zero_off_a: assert property ((irq_thr == '0) |-> ##1 !irq_request)
    else $error("interrupt raised with zero threshold");
  irq_ack_drop_a: assert property ((irq_request && irq_ack && !(irq_cond && !irq_cond_q)) |=> !irq_request)
    else $error("interrupt held after acknowledge");
  mode_set_bits_a: assert property (wr_mode_set |=> (mode & $past(reg_wdata)) == $past(reg_wdata))
    else $error("mode set write did not set bits");
  mode_clr_bits_a: assert property (wr_mode_clr |=> (mode & $past(reg_wdata)) == 16'h0000)
    else $error("mode clear write did not clear bits");
  cnt_rst_a: assert property (wr_cnt_rst |=> evt_count == 24'h000000)
    else $error("counter not cleared by counter reset");
  front_mode_keep_a: assert property ((soft_pulse && !wr_ctrl1) |=> ctrl1 == ($past(ctrl1) & `CTRL1_KEEP_MASK))
    else $error("soft reset changed control one wrongly");
  berr_gate_a: assert property ((emit_valid && !berr_en) |=> !ent[$past(ent_wr_sel)][32])
    else $error("bus error without enable");
  manual_hold_a: assert property ((!auto_advance && !wr_next_word && !skip_event && !data_pulse)
    |=> rd_ptr == $past(rd_ptr))
    else $error("read pointer moved without request");
  empty_nv_a: assert property ((emit_valid && buf_empty) |-> emit_word == `NOT_VALID_WORD)
    else $error("empty buffer returned data");
  block_done_a: assert property ((emit_valid && block_end && blk_done && !data_pulse)
    |=> ent[$past(ent_wr_sel)] [31:0] == `NOT_VALID_WORD)
    else $error("data sent after end word in block-end mode");
  base_sel_a: assert property (select_decoder |-> module_base_addr == {addr_hi, addr_lo})
    else $error("decoder base address not selected");

  // Pointers, counter and interrupt step by step
  // A full buffer takes no word
  full_hold_a: assert property ((buf_full && !data_pulse) |=> wr_ptr == $past(wr_ptr))
    else $error("write taken while buffer full");
  // One manual word step per write
  word_step_a: assert property ((wr_next_word && !buf_empty && !auto_advance && !skip_event && !data_pulse)
    |=> rd_ptr == $past(rd_ptr) + (BUF_AW+1)'(1))
    else $error("next-word write did not advance one word");
  // Counter steps on each counted event
  count_step_a: assert property ((cnt_inc && !cnt_clear) |=> evt_count == $past(evt_count) + 24'h000001)
    else $error("event counter did not count");
  // Data reset leaves the buffer empty
  data_clear_a: assert property (data_pulse |=> buf_empty)
    else $error("data reset left words in buffer");
  // Threshold reached raises the request
  irq_rise_a: assert property ((irq_cond && !irq_cond_q) |=> irq_request)
    else $error("interrupt missing at threshold");

  berr_seen_c: cover property (emit_berr ##1 out_valid && bus_error_output);
  irq_seen_c: cover property (!irq_request ##1 irq_request);
  stall_full_c: cover property (ent_count == 2'd2 && !out_ready);
  pad_seen_c: cover property (pad_pending && emit_valid);
  front_soft_c: cover property (front_reset && front_mode);
endmodule

//--- test/readout_sink.sv
`timescale 1ns/1ns
// Readout receiver standing in for the bus master that drains data
module readout_sink (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [31:0] out_word,
  input  wire logic        out_valid,
  input  wire logic        bus_error_output,
  input  wire logic        stall,
  output logic             out_ready
);
  logic [31:0] words[$];
  logic        errs[$];
  logic        phase = 1'b0;

  // Ready moves off the sampling edge; stall takes every other cycle only
  always @(negedge clk) begin
    phase <= ~phase;
    out_ready <= !stall || phase;
  end

  // Each taken word is kept with its bus error flag
  always @(posedge clk) begin
    if (!reset && out_valid && out_ready) begin
      words.push_back(out_word);
      errs.push_back(bus_error_output);
    end
  end
endmodule

//--- test/qdc_readout_control_regs_tb.sv
`timescale 1ns/1ns
`include "qdc_readout_params.svh"
module qdc_readout_control_regs_tb;
  localparam logic [31:0] hw = 32'h0200_0000;
  localparam logic [31:0] dw = 32'h0000_0abc;
  localparam logic [31:0] ew = 32'h0400_0000;
  localparam logic [31:0] nv = `NOT_VALID_WORD;
  localparam logic [15:0] st_empty = 16'h00a2;
  localparam logic [15:0] st_some  = 16'h00a0;
  logic        clk = 1'b0, reset = 1'b1, stall = 1'b0;
  logic [15:0] reg_addr = 16'h0000, reg_wdata = 16'h0000, rotary_addr = 16'h1234;
  logic        reg_write = 1'b0, reg_read = 1'b0, acq_valid = 1'b0, trigger_seen = 1'b0;
  logic        event_accepted = 1'b0, readout_active = 1'b0, block_transfer = 1'b0;
  logic        front_reset = 1'b0, soft_reset_hold = 1'b0, select_decoder = 1'b0, irq_ack = 1'b0;
  logic        daughter_type_c1 = 1'b1, daughter_type_c0 = 1'b0;
  logic        daughter_type_d1 = 1'b1, daughter_type_d0 = 1'b0;
  logic [31:0] acq_word = 32'h0000_0000;
  logic [15:0] reg_rdata, module_base_addr, fast_clear_cycles, d;
  logic        reg_ack, acq_ready, out_valid, out_ready, bus_error_output, irq_request;
  logic [31:0] out_word;
  logic [`FC_BITS-1:0] fast_clear_width;
  qdc_readout_pkg::chain_role_e chain_role;
  qdc_readout_pkg::chain_role_e exp_role[4] = '{qdc_readout_pkg::CHAIN_OFF, qdc_readout_pkg::CHAIN_LAST,
                                                qdc_readout_pkg::CHAIN_FIRST, qdc_readout_pkg::CHAIN_MIDDLE};
  int          n_fail = 0, n_compared = 0;

  qdc_readout_control_regs #(.BUF_AW(3)) DUT (.clk, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .reg_ack, .acq_word, .acq_valid, .acq_ready, .trigger_seen, .event_accepted, .readout_active,
    .block_transfer, .out_word, .out_valid, .out_ready, .bus_error_output, .front_reset, .soft_reset_hold,
    .select_decoder, .rotary_addr, .module_base_addr, .daughter_type_c1, .daughter_type_c0, .daughter_type_d1,
    .daughter_type_d0, .irq_ack, .irq_request, .chain_role, .fast_clear_width, .fast_clear_cycles);
  readout_sink snk (.clk, .reset, .out_word, .out_valid, .bus_error_output, .stall, .out_ready);

  // 100 MHz clock
  always #5 clk = ~clk;

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, m, got, exp);
    end
  endtask
  // Register bus: one-cycle strobe, answer one cycle later
  task wr(input logic [15:0] a, input logic [15:0] v);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = v;
    reg_write = 1'b1;
    @(negedge clk);
    reg_write = 1'b0;
  endtask
  task rc(input logic [15:0] a, input logic [15:0] exp, input string m);
    @(negedge clk);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge clk);
    reg_read = 1'b0;
    d = reg_ack ? reg_rdata : 16'hdead;
    chk(d, exp, m);
  endtask
  task push(input logic [31:0] w);
    int k;
    k = 0;
    @(negedge clk);
    while (!acq_ready && k < 20) begin
      @(negedge clk);
      k++;
    end
    chk(acq_ready, 1'b1, "buffer accepts word");
    acq_word = w;
    acq_valid = 1'b1;
    @(negedge clk);
    acq_valid = 1'b0;
  endtask
  // Header, n-2 data words, end word
  task evt(input int n);
    push(hw);
    for (int i = 0; i < n - 2; i++) push(dw);
    push(ew);
  endtask
  task trig(input logic acc);
    @(negedge clk);
    trigger_seen = 1'b1;
    event_accepted = acc;
    @(negedge clk);
    trigger_seen = 1'b0;
    event_accepted = 1'b0;
  endtask
  // Block readout with a stalling receiver
  task drain;
    @(negedge clk);
    snk.words.delete();
    snk.errs.delete();
    stall = 1'b1;
    block_transfer = 1'b1;
    readout_active = 1'b1;
    repeat (30) @(negedge clk);
    readout_active = 1'b0;
    repeat (6) @(negedge clk);
    block_transfer = 1'b0;
    stall = 1'b0;
  endtask
  task cmpw(input logic [31:0] e[$]);
    foreach (e[i]) chk(snk.words[i], e[i], "readout word");
  endtask
  task done(input string s);
    $display("test %s done", s);
  endtask
  task results;
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    #100000;
    n_fail++;
    results();
  end

  // Test sequence
  initial begin
    repeat (5) @(negedge clk);
    reset = 1'b0;
    rc(`OFF_CTRL1, 16'h0000, "ctrl1 reset");
    rc(`OFF_IRQ_THR, 16'h0000, "threshold reset");
    rc(`OFF_MODE_SET, `MODE_RESET, "mode reset");
    rc(`OFF_STATUS2, st_empty, "status reset");
    wr(`OFF_MODE_SET, 16'h0001);
    rc(`OFF_MODE_SET, 16'h4801, "mode set");
    wr(`OFF_MODE_CLR, 16'h0001);
    rc(`OFF_MODE_SET, 16'h4800, "mode clear");
    wr(`OFF_CTRL1, 16'h0074);
    rc(`OFF_CTRL1, 16'h0074, "ctrl1 write");
    wr(`OFF_ONESHOT, 16'h0000);
    rc(`OFF_CTRL1, 16'h0010, "one-shot reset");
    done("registers");
    wr(`OFF_ADDR_HI, 16'h00ab);
    wr(`OFF_ADDR_LO, 16'h00cd);
    rc(`OFF_ADDR_HI, 16'h00ab, "decoder high");
    chk(module_base_addr, 16'h1234, "rotary base");
    select_decoder = 1'b1;
    #1 chk(module_base_addr, 16'habcd, "decoder base");
    for (int i = 0; i < 4; i++) begin
      wr(`OFF_CHAIN, 16'(i));
      chk(chain_role, exp_role[i], "chain role");
    end
    wr(`OFF_FC_WIN, 16'h03f0);
    rc(`OFF_FC_WIN, 16'h03f0, "window readback");
    chk(fast_clear_cycles, 16'h0f0a, "window cycles");
    chk(fast_clear_width, 10'h3f0, "window width");
    done("address");
    repeat (3) trig(1'b0);
    rc(`OFF_CNT_LO, 16'h0003, "all triggers");
    wr(`OFF_CNT_RST, 16'h0000);
    rc(`OFF_CNT_LO, 16'h0000, "counter reset");
    wr(`OFF_MODE_CLR, 16'h4000);
    rc(`OFF_MODE_SET, 16'h0800, "count mode");
    trig(1'b0);
    trig(1'b1);
    rc(`OFF_CNT_LO, 16'h0001, "accepted only");
    rc(`OFF_CNT_HI, 16'h0000, "count high");
    done("counter");
    wr(`OFF_CTRL1, 16'h0024);
    wr(`OFF_IRQ_THR, 16'h0001);
    evt(3);
    repeat (2) @(negedge clk);
    chk(irq_request, 1'b1, "irq at threshold");
    irq_ack = 1'b1;
    @(negedge clk);
    irq_ack = 1'b0;
    @(negedge clk);
    chk(irq_request, 1'b0, "irq acknowledged");
    evt(2);
    drain();
    cmpw('{hw, dw, ew, nv});
    chk(snk.errs[2], 1'b1, "error on end word");
    wr(`OFF_CTRL1, 16'h0020);
    drain();
    cmpw('{hw, ew, nv});
    chk({snk.errs[0], snk.errs[1]}, 2'b01, "error on last word");
    wr(`OFF_CTRL1, 16'h0040);
    evt(3);
    evt(2);
    drain();
    cmpw('{hw, dw, ew, nv, hw, ew});
    chk(snk.errs[5], 1'b0, "no error when disabled");
    done("readout");
    wr(`OFF_MODE_CLR, 16'h0800);
    evt(2);
    readout_active = 1'b1;
    repeat (8) @(negedge clk);
    readout_active = 1'b0;
    rc(`OFF_STATUS2, st_some, "reads keep pointer");
    wr(`OFF_NEXT_WORD, 16'h0000);
    rc(`OFF_STATUS2, st_some, "one word advanced");
    wr(`OFF_NEXT_WORD, 16'h0000);
    rc(`OFF_STATUS2, st_empty, "end word passed");
    evt(3);
    wr(`OFF_NEXT_EVT, 16'h0000);
    repeat (5) @(negedge clk);
    rc(`OFF_STATUS2, st_empty, "next event");
    done("manual advance");
    repeat (8) push(dw);
    rc(`OFF_STATUS2, 16'h00a4, "buffer full");
    chk(acq_ready, 1'b0, "full refuses");
    front_reset = 1'b1;
    @(negedge clk);
    front_reset = 1'b0;
    rc(`OFF_STATUS2, st_empty, "data reset");
    rc(`OFF_CNT_LO, 16'h0000, "data reset count");
    wr(`OFF_CTRL1, 16'h0014);
    front_reset = 1'b1;
    @(negedge clk);
    front_reset = 1'b0;
    rc(`OFF_CTRL1, 16'h0010, "front soft reset");
    done("fill");
    results();
  end
endmodule
